//--- hdl/ebarb_map.svh
// How it works
// - Reset deasserts request, returns to slave
// - Stop/wait: hold bit keeps request, else deassert
// - Request follows external bus need
// - Hold bit forces request asserted
// - Only external accesses or the hold bit raise request
// - Wait busy high after grant, then master
// - Grant removed: release at cycle end
// - Master may park holding busy asserted
// - Busy released by brief high drive
// - Busy line driven synchronous to clock
// - Column strobe driven when master or mastership enable bit set, else tri-state
// - Bus clock toggles only master with trace
// - Bus clock runs at half the clock rate, toggling on rising edges
// - Inverted bus clock driven while master, complements only with trace
`ifndef EBARB_MAP_SVH
`define EBARB_MAP_SVH
`define EBARB_PULLUP_CYCLES 2'h1
`define EBARB_ASSERTED_N 1'b0
`define EBARB_DEASSERTED_N 1'b1
`endif

//--- hdl/ebarb_pkg.sv
package ebarb_pkg;
    typedef enum logic [1:0] {
        ebarb_slave,
        ebarb_pending,
        ebarb_master,
        ebarb_release
    } ebarb_state_type;
    typedef struct packed {
        logic ext_need;
        logic cycle_end;
        logic request_hold_bit;
        logic mastership_enable_bit;
        logic address_trace_enable;
        logic low_power;
        logic cas_drive;
    } ebarb_ctrl_type;
    typedef struct packed {
        logic value;
        logic oe;
    } ebarb_pin_type;
endpackage

//--- hdl/ebarb_clkgen.sv
`include "ebarb_map.svh"
// Half-rate bus clock: toggles on each rising edge of the core clock while enabled
module ebarb_clkgen
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic enable_in,
    // Output
    output logic bclk_out
);
    import ebarb_pkg::*;
    logic phase;
    logic next_phase;
    always_comb
    begin
        next_phase = enable_in ? ~phase : 1'b0;
    end
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            phase <= 1'b0;
        else
            phase <= next_phase;
    end
    assign bclk_out = phase;
endmodule // ebarb_clkgen

//--- hdl/ebarb_top.sv
`include "ebarb_map.svh"
module ebarb_top
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Core side control
    input wire ebarb_pkg::ebarb_ctrl_type ctrl_in,
    // Arbitration pins
    input wire logic bus_grant_n_in,
    input wire logic bus_busy_n_in,
    output logic bus_request_n_out,
    output logic bus_busy_n_out,
    output logic bus_busy_n_oe_out,
    // Strobes, bus clocks and master status
    output ebarb_pkg::ebarb_pin_type cas_n_out,
    output ebarb_pkg::ebarb_pin_type bclk_out,
    output ebarb_pkg::ebarb_pin_type bclk_n_out,
    output logic master_out
);
    import ebarb_pkg::*;
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ebarb_state_type state;
    ebarb_state_type next_state;
    logic req_n;
    logic next_req_n;
    logic busy_n;
    logic next_busy_n;
    logic busy_oe;
    logic next_busy_oe;
    logic [1:0] pull_cnt;
    logic [1:0] next_pull_cnt;
    ebarb_pin_type cas_q;
    ebarb_pin_type next_cas;
    ebarb_pin_type bclk_q;
    ebarb_pin_type next_bclk;
    ebarb_pin_type bclkn_q;
    ebarb_pin_type next_bclkn;
    logic master;
    logic next_master;
    logic clk_phase;
    logic trace_on;

    assign trace_on = (state == ebarb_master) && ctrl_in.address_trace_enable
        && !ctrl_in.low_power;

    ebarb_clkgen u_clkgen
    (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .enable_in(trace_on),
        .bclk_out(clk_phase)
    );

    always_comb
    begin
        next_state = state;
        next_busy_n = busy_n;
        next_busy_oe = busy_oe;
        next_pull_cnt = pull_cnt;
        if (ctrl_in.low_power)
        begin
            next_req_n = ctrl_in.request_hold_bit ? req_n : `EBARB_DEASSERTED_N;
        end
        else if (ctrl_in.ext_need || ctrl_in.request_hold_bit)
            next_req_n = `EBARB_ASSERTED_N;
        else
            next_req_n = `EBARB_DEASSERTED_N;
        unique case (state)
            ebarb_slave:
            begin
                next_busy_oe = 1'b0;
                next_busy_n = `EBARB_DEASSERTED_N;
                if (!ctrl_in.low_power && bus_grant_n_in == `EBARB_ASSERTED_N)
                    next_state = ebarb_pending;
            end
            ebarb_pending:
            begin
                if (ctrl_in.low_power || bus_grant_n_in != `EBARB_ASSERTED_N)
                    next_state = ebarb_slave;
                else if (bus_busy_n_in == `EBARB_DEASSERTED_N)
                begin
                    next_state = ebarb_master;
                    next_busy_oe = 1'b1;
                    next_busy_n = `EBARB_ASSERTED_N;
                end
            end
            ebarb_master:
            begin
                // Parked: busy held while grant stays and low power is off, need or not
                if (ctrl_in.low_power
                    || (bus_grant_n_in != `EBARB_ASSERTED_N && ctrl_in.cycle_end))
                begin
                    next_state = ebarb_release;
                    next_busy_n = `EBARB_DEASSERTED_N;
                    next_pull_cnt = `EBARB_PULLUP_CYCLES;
                end
            end
            ebarb_release:
            begin
                if (pull_cnt == 2'h1)
                begin
                    next_busy_oe = 1'b0;
                    next_state = ebarb_slave;
                end
                next_pull_cnt = pull_cnt - 2'h1;
            end
        endcase
        next_master = (next_state == ebarb_master);
        next_cas.oe = next_master || ctrl_in.mastership_enable_bit;
        next_cas.value = next_master ? !ctrl_in.cas_drive : `EBARB_DEASSERTED_N;
        next_bclk.oe = trace_on;
        next_bclk.value = trace_on ? clk_phase : 1'b0;
        next_bclkn.oe = master;
        next_bclkn.value = trace_on ? !clk_phase : 1'b1;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ebarb_slave;
            req_n <= `EBARB_DEASSERTED_N;
            busy_n <= `EBARB_DEASSERTED_N;
            busy_oe <= 1'b0;
            pull_cnt <= 2'h0;
            cas_q <= '{value: 1'b1, oe: 1'b0};
            bclk_q <= '{value: 1'b0, oe: 1'b0};
            bclkn_q <= '{value: 1'b1, oe: 1'b0};
            master <= 1'b0;
        end
        else
        begin
            state <= next_state;
            req_n <= next_req_n;
            busy_n <= next_busy_n;
            busy_oe <= next_busy_oe;
            pull_cnt <= next_pull_cnt;
            cas_q <= next_cas;
            bclk_q <= next_bclk;
            bclkn_q <= next_bclkn;
            master <= next_master;
        end
    end

    assign bus_request_n_out = req_n;
    assign bus_busy_n_out = busy_n;
    assign bus_busy_n_oe_out = busy_oe;
    assign cas_n_out = cas_q;
    assign bclk_out = bclk_q;
    assign bclk_n_out = bclkn_q;
    assign master_out = master;
endmodule // ebarb_top

//--- verif/ebarb_asserts.sv
module ebarb_asserts
(
    // Watched ports
    input wire logic sys_clk_in, reset_n_in, bus_grant_n_in, bus_busy_n_in,
    input wire ebarb_pkg::ebarb_ctrl_type ctrl_in,
    input wire logic bus_request_n_out, bus_busy_n_out, bus_busy_n_oe_out, master_out,
    input wire ebarb_pkg::ebarb_pin_type bclk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import ebarb_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    req_follow_a: assert property (!ctrl_in.low_power |=>
        bus_request_n_out == !$past(ctrl_in.ext_need | ctrl_in.request_hold_bit))
        else $error("request wrong");
    lp_hold_a: assert property (ctrl_in.low_power && ctrl_in.request_hold_bit
        |=> $stable(bus_request_n_out)) else $error("request not held");
    lp_drop_a: assert property (ctrl_in.low_power && !ctrl_in.request_hold_bit
        |=> bus_request_n_out) else $error("request not dropped");
    take_wait_a: assert property ($rose(master_out) |-> $past(bus_busy_n_in))
        else $error("took busy bus");
    take_drive_a: assert property ($rose(master_out) |-> bus_busy_n_oe_out &&
        !bus_busy_n_out) else $error("busy not driven");
    release_a: assert property (master_out && bus_grant_n_in && ctrl_in.cycle_end
        |=> !master_out && bus_busy_n_out && bus_busy_n_oe_out ##1 !bus_busy_n_oe_out)
        else $error("bad release");
    hold_master_a: assert property (master_out && !ctrl_in.cycle_end &&
        !ctrl_in.low_power |=> master_out) else $error("lost mastership");
    bclk_toggle_a: assert property (bclk_out.oe && $past(bclk_out.oe) |->
        bclk_out.value != $past(bclk_out.value)) else $error("bus clock stuck");
endmodule // ebarb_asserts
bind ebarb_top ebarb_asserts u_chk (.*);

//--- verif/ebarb_arb_model.sv
module ebarb_arb_model
(
    // Clock, reset and device pins
    input wire logic clk_in, rst_n_in, req_n_in, dev_busy_n_in, dev_oe_in,
    // Bench controls
    input wire logic park_in, other_busy_in,
    // Bus side
    output logic grant_n_out, busy_wire_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Grant follows request, or stays low to park the bus
    always_ff @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
            grant_n_out <= 1'b1;
        else
            grant_n_out <= req_n_in & ~park_in;
    // Pull-up wins unless a master drives low
    assign busy_wire_out = ~(other_busy_in | (dev_oe_in & ~dev_busy_n_in));
endmodule // ebarb_arb_model

//--- verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ebarb_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, park = 1'b0, oth = 1'b0;
    logic gnt_n, bw, req_n, b_n, b_oe, mst, v;
    ebarb_ctrl_type ctrl = '0;
    ebarb_pin_type cas, bc, bcn;
    int err_total = 0, checked = 0;
    always #20 clk = ~clk;
    ebarb_top dut (.sys_clk_in(clk), .reset_n_in(rst_n), .ctrl_in(ctrl),
        .bus_grant_n_in(gnt_n), .bus_busy_n_in(bw), .bus_request_n_out(req_n),
        .bus_busy_n_out(b_n), .bus_busy_n_oe_out(b_oe), .cas_n_out(cas),
        .bclk_out(bc), .bclk_n_out(bcn), .master_out(mst));
    ebarb_arb_model arb (.clk_in(clk), .rst_n_in(rst_n), .req_n_in(req_n),
        .dev_busy_n_in(b_n), .dev_oe_in(b_oe), .park_in(park),
        .other_busy_in(oth), .grant_n_out(gnt_n), .busy_wire_out(bw));
    task chk(input logic s, input logic e);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %0t seen %b", $time, s);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task t_req;
        @(posedge clk) {oth, ctrl.ext_need} <= 2'h3;
        cyc(1);
        chk(req_n, 1'b0);
        @(posedge clk) {ctrl.ext_need, ctrl.request_hold_bit} <= 2'h1;
        cyc(2);
        chk(req_n, 1'b0);
        @(posedge clk) ctrl.low_power <= 1'b1;
        cyc(3);
        chk(req_n, 1'b0);
        @(posedge clk) ctrl.request_hold_bit <= 1'b0;
        cyc(2);
        chk(req_n, 1'b1);
    endtask
    task t_take;
        @(posedge clk) {ctrl.low_power, ctrl.ext_need, ctrl.address_trace_enable} <= 3'h3;
        cyc(4);
        chk(mst, 1'b0);
        @(posedge clk) oth <= 1'b0;
        for (int i = 0; i < 8 && mst !== 1'b1; i++)
            cyc(1);
        if (mst !== 1'b1)
        begin
            err_total++;
            end_of_test;
        end
        chk(b_n, 1'b0);
        chk(cas.oe, 1'b1);
        cyc(2);
        v = bc.value;
        cyc(1);
        chk(bc.value, ~v);
        chk(bcn.value, v);
    endtask
    task t_park;
        @(posedge clk) {park, ctrl.ext_need} <= 2'h2;
        ctrl.cas_drive <= 1'b1;
        cyc(4);
        chk(req_n, 1'b1);
        chk(mst, 1'b1);
        chk(cas.value, 1'b0);
        @(posedge clk) park <= 1'b0;
        cyc(3);
        chk(mst, 1'b1);
        @(posedge clk) ctrl.cycle_end <= 1'b1;
        @(posedge clk) ctrl.cycle_end <= 1'b0;
        #1;
        chk(b_n, 1'b1);
        cyc(1);
        chk(b_oe, 1'b0);
        chk(cas.oe, 1'b0);
        chk(bc.oe, 1'b0);
        chk(bcn.oe, 1'b0);
        chk(cas.value, 1'b1);
        @(posedge clk) ctrl.mastership_enable_bit <= 1'b1;
        cyc(1);
        chk(cas.oe, 1'b1);
        chk(cas.value, 1'b1);
    endtask
    initial
    begin
        cyc(1);
        chk(req_n, 1'b1);
        chk(b_oe, 1'b0);
        @(posedge clk) rst_n <= 1'b1;
        // Internal reset copy is released two edges later
        cyc(2);
        t_req;
        t_take;
        t_park;
        end_of_test;
    end
endmodule // testbench
